// File: verilog/sap_operand_crc.v
/*
 * operand placement, exponent walk control and crc engine of the
 * security accelerator. holds blinded address mapping for operands,
 * the arithmetic engine clock enable, the square/multiply sequencer
 * over exponent bits, and the crc over 32-bit data-out words.
 * assumes synchronous inputs on sys_clk, software-visible bits as ports,
 * and an external datapath that performs squares and multiplies.
 */
//
// Overview of operation
// - each operand gets own blinded start position
// - code 00/01/10/11 shifts 0/40/80/c0, wrapping
// - engine clock is low-power clock or half
// - optimize set skips multiply on zero bits
// - optimize resets 0; multiply after first one
// - word size 1..2048 applies to all operands
// - oversize operand: bad result, no error
// - only 64-bit padded blocks are read
// - temp and result hold round values
// - operand b reused as temporary storage
// - crc accepts sram data only, not flash
// - crc fed by four data-out words
// - 32-bit polynomial, top term implied
// - polynomial resets to edb88320
// - default lsb first, right shifting
// - msb mode shifts left, poly left-justified
// - crc is linear; preset usually all ones
// - modulus instance 5, exponent instance 4
// - refuse start on invalid word size
`timescale 1ns/10ps
`include "sap_defs.vh"

module sap_operand_crc (
    sys_clk,
    srst,
    low_power_clock,
    system_clock_divider_select,
    operand_a_blind_select,
    operand_b_blind_select,
    exponent_blind_select,
    modulus_blind_select,
    op_a_instance,
    op_b_instance,
    op_a_offset,
    op_b_offset,
    op_e_offset,
    op_m_offset,
    op_e_instance,
    op_m_instance,
    op_block_count,
    arith_word_size_field,
    word_size_valid,
    optimize,
    exp_start,
    exp_bit,
    step_ack,
    exp_busy,
    exp_bit_idx,
    do_square,
    do_multiply,
    exp_done,
    exp_refused,
    square_dst_b,
    crc_src_is_sram,
    crc_word_valid,
    crc_word_idx,
    crc_word_data,
    crc_poly_we,
    crc_poly_wdata,
    crc_val_we,
    crc_val_wdata,
    bit_swap,
    crc_polynomial_reg,
    crc_value,
    crc_word_taken
);
    input  wire        sys_clk;                     // 250 mhz system clock
    input  wire        srst;                        // synchronous reset, high
    input  wire        low_power_clock;             // low-power clock level
    input  wire        system_clock_divider_select; // 1: engine runs at half
    input  wire [1:0]  operand_a_blind_select;      // blind code for a
    input  wire [1:0]  operand_b_blind_select;      // blind code for b
    input  wire [1:0]  exponent_blind_select;       // blind code for e
    input  wire [1:0]  modulus_blind_select;        // blind code for m
    input  wire [2:0]  op_a_instance;               // instance chosen for a
    input  wire [2:0]  op_b_instance;               // instance chosen for b
    output reg  [10:0] op_a_offset;                 // byte offset of a start
    output reg  [10:0] op_b_offset;                 // byte offset of b start
    output reg  [10:0] op_e_offset;                 // byte offset of e start
    output reg  [10:0] op_m_offset;                 // byte offset of m start
    output wire [2:0]  op_e_instance;               // fixed exponent instance
    output wire [2:0]  op_m_instance;               // fixed modulus instance
    output reg  [5:0]  op_block_count;              // 64-bit blocks per operand
    input  wire [11:0] arith_word_size_field;       // operation size in bits
    output wire        word_size_valid;             // size within 1..2048
    input  wire        optimize;                    // skip zero-bit multiplies
    input  wire        exp_start;                   // pulse: start exponentiation
    input  wire        exp_bit;                     // exponent bit at exp_bit_idx
    input  wire        step_ack;                    // datapath finished a step
    output wire        exp_busy;                    // sequencer active
    output reg  [10:0] exp_bit_idx;                 // exponent bit being examined
    output reg         do_square;                   // request square step
    output reg         do_multiply;                 // request multiply step
    output reg         exp_done;                    // pulse: walk finished
    output reg         exp_refused;                 // pulse: start refused
    output reg         square_dst_b;                // square results land in b
    input  wire        crc_src_is_sram;             // data came from sram
    input  wire        crc_word_valid;              // data-out word write strobe
    input  wire [1:0]  crc_word_idx;                // which data-out word 0..3
    input  wire [31:0] crc_word_data;               // data-out word value
    input  wire        crc_poly_we;                 // polynomial write strobe
    input  wire [31:0] crc_poly_wdata;              // polynomial write data
    input  wire        crc_val_we;                  // crc seed write strobe
    input  wire [31:0] crc_val_wdata;               // crc seed value
    input  wire        bit_swap;                    // 1: msb first
    output wire [31:0] crc_polynomial_reg;          // current polynomial
    output wire [31:0] crc_value;                   // running crc
    output reg         crc_word_taken;              // pulse: word folded in

    // one-hot sequencer states
    localparam [4:0] ST_IDLE = 5'b00001; // waiting for start
    localparam [4:0] ST_SCAN = 5'b00010; // skipping leading zeros
    localparam [4:0] ST_SQR  = 5'b00100; // square in progress
    localparam [4:0] ST_MUL  = 5'b01000; // multiply in progress
    localparam [4:0] ST_NEXT = 5'b10000; // move to lower bit

    reg  [4:0]  st_q;              // sequencer state
    reg         lp_q;              // last low-power clock level
    reg         half_q;            // toggle for divide by two
    reg         eng_en;            // engine enable pulse
    reg  [31:0] poly_q;            // polynomial register
    reg  [31:0] crc_q;             // crc value register
    wire [31:0] crc_next;          // crc after one word

    function [7:0] blind_shift;
        input [1:0] code;
        begin
            case (code)
                `SAP_BLIND_S1: blind_shift = `SAP_SHIFT_S1;
                `SAP_BLIND_S2: blind_shift = `SAP_SHIFT_S2;
                `SAP_BLIND_S3: blind_shift = `SAP_SHIFT_S3;
                default:       blind_shift = `SAP_SHIFT_NONE;
            endcase
        end
    endfunction

    assign op_m_instance = `SAP_INST_MODULUS;
    assign op_e_instance = `SAP_INST_EXPONENT;

    // independent start positions; offset is instance*256 plus shift
    // the datapath wraps low byte within the instance so it never spills
    always @(posedge sys_clk) begin
        if (srst) begin
            op_a_offset <= 11'h000;
            op_b_offset <= 11'h000;
            op_e_offset <= 11'h000;
            op_m_offset <= 11'h000;
        end else begin
            op_a_offset <= {op_a_instance, blind_shift(operand_a_blind_select)};
            op_b_offset <= {op_b_instance, blind_shift(operand_b_blind_select)};
            op_e_offset <= {`SAP_INST_EXPONENT, blind_shift(exponent_blind_select)};
            op_m_offset <= {`SAP_INST_MODULUS, blind_shift(modulus_blind_select)};
        end
    end

    assign word_size_valid = (arith_word_size_field >= `SAP_WS_MIN) &&
                             (arith_word_size_field <= `SAP_WS_MAX);

    // blocks read per operand, rounded to 64 bits; words past this
    // are never fetched so their contents do not matter
    always @(posedge sys_clk) begin
        if (srst) begin
            op_block_count <= 6'h00;
        end else begin
            op_block_count <= arith_word_size_field[11:6] +
                              {5'h00, |(arith_word_size_field & `SAP_BLK_MASK)};
        end
    end

    // engine enable: each low-power rising edge, or every other one
    // edge detect sees a synchronous input, so no synchroniser stage here
    always @(posedge sys_clk) begin
        if (srst) begin
            lp_q   <= 1'b0;
            half_q <= 1'b0;
            eng_en <= 1'b0;
        end else begin
            lp_q   <= low_power_clock;
            eng_en <= 1'b0;
            if (low_power_clock && !lp_q) begin
                half_q <= ~half_q;
                eng_en <= system_clock_divider_select ? half_q : 1'b1;
            end
        end
    end

    assign exp_busy = ~st_q[0];

    // exponent walk from top bit down; bit moves and squares only on engine enable, multiply on step_ack
    // no size check on operand contents: oversize just yields garbage
    always @(posedge sys_clk) begin
        if (srst) begin
            st_q         <= ST_IDLE;
            exp_bit_idx  <= `SAP_EIDX_ZERO;
            do_square    <= 1'b0;
            do_multiply  <= 1'b0;
            exp_done     <= 1'b0;
            exp_refused  <= 1'b0;
            square_dst_b <= 1'b0;
        end else begin
            exp_done    <= 1'b0;
            exp_refused <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (exp_start) begin
                        if (!word_size_valid) begin
                            exp_refused <= 1'b1;
                        end else begin
                            exp_bit_idx <= arith_word_size_field[10:0] - `SAP_ONE_IDX;
                            st_q        <= ST_SCAN;
                        end
                    end
                end
                ST_SCAN: begin
                    if (eng_en) begin
                        if (exp_bit) begin
                            // first one: result seeded, go to next bit
                            st_q <= ST_NEXT;
                        end else if (exp_bit_idx == `SAP_EIDX_ZERO) begin
                            exp_done <= 1'b1;
                            st_q     <= ST_IDLE;
                        end else begin
                            exp_bit_idx <= exp_bit_idx - `SAP_ONE_IDX;
                        end
                    end
                end
                ST_SQR: begin
                    // square lands in b segment as scratch
                    // t and r hold round values meanwhile
                    if (step_ack) begin
                        do_square <= 1'b0;
                        if (optimize && !exp_bit) begin
                            st_q <= ST_NEXT;
                        end else begin
                            do_multiply <= 1'b1;
                            st_q        <= ST_MUL;
                        end
                    end
                end
                ST_MUL: begin
                    if (step_ack) begin
                        do_multiply <= 1'b0;
                        st_q        <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    if (eng_en) begin
                        if (exp_bit_idx == `SAP_EIDX_ZERO) begin
                            exp_done     <= 1'b1;
                            square_dst_b <= 1'b0;
                            st_q         <= ST_IDLE;
                        end else begin
                            exp_bit_idx  <= exp_bit_idx - `SAP_ONE_IDX;
                            do_square    <= 1'b1;
                            square_dst_b <= 1'b1;
                            st_q         <= ST_SQR;
                        end
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // crc word fold, shared combinational core
    sap_crc_word u_crc_word (
        .crc_in    (crc_q),
        .poly      (poly_q),
        .data      (crc_word_data),
        .msb_first (bit_swap),
        .crc_out   (crc_next)
    );

    assign crc_polynomial_reg = poly_q;
    assign crc_value          = crc_q;

    // polynomial and crc value registers
    always @(posedge sys_clk) begin
        if (srst) begin
            poly_q         <= `SAP_CRC_POLY_RST;
            crc_q          <= `SAP_CRC_VAL_RST;
            crc_word_taken <= 1'b0;
        end else begin
            crc_word_taken <= 1'b0;
            // full 32 bits stored, top term implied
            if (crc_poly_we) begin
                poly_q <= crc_poly_wdata;
            end
            if (crc_val_we) begin
                crc_q <= crc_val_wdata;
            end else if (crc_word_valid && crc_src_is_sram) begin
                // any of the four data-out words feeds in
                // direction chosen by bit_swap in the core
                crc_q          <= crc_next;
                crc_word_taken <= 1'b1;
            end
        end
    end
endmodule

// File: verilog/sap_defs.vh
/*
 * constants for the security accelerator operand placement and crc engine:
 * blind offsets, instance numbers, word-size limits, crc reset values.
 * assumes it is included by bare name from the design files.
 */
`ifndef SAP_DEFS_VH
`define SAP_DEFS_VH

// blinding shift codes and byte offsets inside one 256-byte instance
`define SAP_BLIND_NONE      2'b00
`define SAP_BLIND_S1        2'b01
`define SAP_BLIND_S2        2'b10
`define SAP_BLIND_S3        2'b11
`define SAP_SHIFT_S1        8'h40
`define SAP_SHIFT_S2        8'h80
`define SAP_SHIFT_S3        8'hc0
`define SAP_SHIFT_NONE      8'h00

// fixed instances for modulus and exponent
`define SAP_INST_MODULUS    3'h5
`define SAP_INST_EXPONENT   3'h4

// word size limits and 64-bit block sizing
`define SAP_WS_MIN          12'h001
`define SAP_WS_MAX          12'h800
`define SAP_BLK_MASK        12'h03f

// crc reset polynomial, reset value and zero word
`define SAP_CRC_POLY_RST    32'hedb88320
`define SAP_CRC_VAL_RST     32'hffffffff
`define SAP_CRC_ZERO        32'h00000000

// exponent walk: bit index width for up to 2048 bits
`define SAP_EIDX_ZERO       11'h000
`define SAP_ONE_IDX         11'h001

`endif

// File: verilog/sap_crc_word.v
/*
 * one 32-bit data word folded into a running crc, combinationally.
 * assumes the caller registers the result; msb_first picks direction.
 */
`timescale 1ns/10ps
`include "sap_defs.vh"

module sap_crc_word (
    crc_in,
    poly,
    data,
    msb_first,
    crc_out
);
    input  wire [31:0] crc_in;     // running crc before this word
    input  wire [31:0] poly;       // polynomial, top term implied
    input  wire [31:0] data;       // word to fold in
    input  wire        msb_first;  // 1: left shifts, msb of data first
    output reg  [31:0] crc_out;    // crc after all 32 bits

    integer     i;                 // bit loop index
    reg  [31:0] c;                 // working crc
    reg         fb;                // feedback bit

    // galois form; linear, so zero crc with zero data stays zero
    always @* begin
        c = crc_in;
        fb = 1'b0;
        for (i = 0; i < 32; i = i + 1) begin
            if (msb_first) begin
                // left justified poly, bit 31 shifts out first
                fb = c[31] ^ data[31 - i];
                c = {c[30:0], 1'b0} ^ (fb ? poly : `SAP_CRC_ZERO);
            end else begin
                // reversed poly, bit 0 shifts out first
                fb = c[0] ^ data[i];
                c = {1'b0, c[31:1]} ^ (fb ? poly : `SAP_CRC_ZERO);
            end
        end
        crc_out = c;
    end
endmodule

// File: testbench/sap_operand_crc_asserts.sv
/*
 * checker for sap_operand_crc: placement, sequencer and crc relations.
 * assumes it sees only top-level ports; bound in below the module.
 */
`timescale 1ns/10ps
module sap_chk (
    input wire        sys_clk,
    input wire        srst,
    input wire [1:0]  operand_a_blind_select,
    input wire [1:0]  operand_b_blind_select,
    input wire [1:0]  exponent_blind_select,
    input wire [1:0]  modulus_blind_select,
    input wire [2:0]  op_a_instance,
    input wire [2:0]  op_b_instance,
    input wire [10:0] op_a_offset,
    input wire [10:0] op_b_offset,
    input wire [10:0] op_e_offset,
    input wire [10:0] op_m_offset,
    input wire [11:0] arith_word_size_field,
    input wire        word_size_valid,
    input wire        optimize,
    input wire        exp_start,
    input wire        exp_bit,
    input wire        step_ack,
    input wire        exp_busy,
    input wire        do_square,
    input wire        do_multiply,
    input wire        exp_refused,
    input wire        square_dst_b,
    input wire        crc_src_is_sram,
    input wire        crc_word_valid,
    input wire        crc_poly_we,
    input wire [31:0] crc_poly_wdata,
    input wire        crc_val_we,
    input wire [31:0] crc_val_wdata,
    input wire [31:0] crc_polynomial_reg,
    input wire [31:0] crc_value,
    input wire        crc_word_taken
);
    // one domain: single clocking and reset for every property
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // shift byte is the code times 0x40, instance stays in the top bits
    property p_ab_off;
        !$past(srst) |-> op_a_offset == {$past(op_a_instance), $past(operand_a_blind_select), 6'h00}
            && op_b_offset == {$past(op_b_instance), $past(operand_b_blind_select), 6'h00};
    endproperty
    a_ab_off: assert property (p_ab_off) else $error("a or b offset wrong");
    // exponent and modulus live in fixed instances 4 and 5
    property p_em_off;
        !$past(srst) |-> op_e_offset == {3'h4, $past(exponent_blind_select), 6'h00}
            && op_m_offset == {3'h5, $past(modulus_blind_select), 6'h00};
    endproperty
    a_em_off: assert property (p_em_off) else $error("e or m offset wrong");
    property p_ws;
        word_size_valid == (arith_word_size_field != 12'h000 && arith_word_size_field <= 12'h800);
    endproperty
    a_ws: assert property (p_ws) else $error("word size validity wrong");
    property p_refuse;
        exp_start && !exp_busy && !word_size_valid |=> exp_refused && !exp_busy;
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad size start not refused");
    property p_accept;
        exp_start && !exp_busy && word_size_valid |=> exp_busy && !exp_refused;
    endproperty
    a_accept: assert property (p_accept) else $error("good size start not taken");
    // after a square, multiply follows unless optimised on a zero bit
    property p_mul;
        do_square && step_ack |=> do_multiply == !($past(optimize) && !$past(exp_bit));
    endproperty
    a_mul: assert property (p_mul) else $error("multiply step decision wrong");
    property p_sqb;
        do_square |-> square_dst_b && exp_busy && !do_multiply;
    endproperty
    a_sqb: assert property (p_sqb) else $error("square not routed to b");
    property p_take;
        !$past(srst) |-> crc_word_taken == $past(crc_word_valid && crc_src_is_sram && !crc_val_we);
    endproperty
    a_take: assert property (p_take) else $error("crc word take wrong");
    property p_seed;
        crc_val_we |=> crc_value == $past(crc_val_wdata);
    endproperty
    a_seed: assert property (p_seed) else $error("crc seed not loaded");
    property p_poly;
        crc_poly_we |=> crc_polynomial_reg == $past(crc_poly_wdata);
    endproperty
    a_poly: assert property (p_poly) else $error("polynomial not loaded");
    property p_rst;
        $fell(srst) |-> crc_polynomial_reg == 32'hedb88320 && crc_value == 32'hffffffff;
    endproperty
    a_rst: assert property (p_rst) else $error("crc reset values wrong");
endmodule

bind sap_operand_crc sap_chk sap_chk_i (.*);

// File: testbench/sap_operand_crc_test.sv
/*
 * self-checking bench for sap_operand_crc: blinding, word size, walk, crc.
 * assumes the design header is on the include path; 250 mhz sys_clk.
 */
`timescale 1ns/10ps
module sap_operand_crc_test;
    logic        sys_clk = 0, srst = 1, low_power_clock = 0, system_clock_divider_select = 0;
    logic [1:0]  operand_a_blind_select = 0, operand_b_blind_select = 0;
    logic [1:0]  exponent_blind_select = 0, modulus_blind_select = 0, crc_word_idx = 0;
    logic [2:0]  op_a_instance = 0, op_b_instance = 0, op_e_instance, op_m_instance;
    logic [10:0] op_a_offset, op_b_offset, op_e_offset, op_m_offset, exp_bit_idx;
    logic [5:0]  op_block_count;
    logic [11:0] arith_word_size_field = 12'h008;
    logic        optimize = 0, exp_start = 0, step_ack = 0, exp_bit, word_size_valid;
    logic        exp_busy, do_square, do_multiply, exp_done, exp_refused, square_dst_b;
    logic        crc_src_is_sram = 1, crc_word_valid = 0, crc_poly_we = 0, crc_val_we = 0;
    logic        bit_swap = 0, crc_word_taken;
    logic [31:0] crc_word_data = 0, crc_poly_wdata = 0, crc_val_wdata = 0;
    logic [31:0] crc_polynomial_reg, crc_value, rnd = 32'ha78659cf, mc, mp;
    logic [63:0] e_q = 0;           // exponent memory seen by the walk
    logic [1:0]  lp_cnt = 0;        // slow clock divider, 4 sys cycles per period
    int          fails = 0, n_checks = 0, cyc = 0, sq, mu, esq, emu, t0, t1;
    logic        rf;

    sap_operand_crc sap_operand_crc_i (.*);

    always #2 sys_clk = ~sys_clk;
    // exponent memory read: bit at the index the walk asks for
    assign exp_bit = e_q[exp_bit_idx[5:0]];
    // low-power clock and hang guard; ceiling well above the ~4k cycle run
    always @(posedge sys_clk) begin
        lp_cnt <= lp_cnt + 2'h1;
        low_power_clock <= lp_cnt[1];
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            stop_test();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // reference fold of one word, bit-serial in either direction
    function automatic logic [31:0] fold(input logic [31:0] c, p, d, input logic msb);
        logic fb;
        for (int i = 0; i < 32; i++) begin
            fb = msb ? c[31] ^ d[31 - i] : c[0] ^ d[i];
            c = msb ? (c << 1) : (c >> 1);
            if (fb) c ^= p;
        end
        return c;
    endfunction
    // expected steps: leading zeros skipped, then one square per lower bit
    function automatic void exp_model(input int ws, input logic [63:0] e, input logic opt);
        int top;
        top = -1;
        for (int i = 0; i < ws; i++) if (e[i]) top = i;
        esq = (top < 0) ? 0 : top;
        emu = 0;
        for (int i = 0; i < top; i++) emu += opt ? int'(e[i]) : 1;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // start a walk and act as the datapath, acking each requested step
    task automatic run_exp(input logic [11:0] ws, input logic [63:0] e, input logic opt, dv);
        int k;
        @(posedge sys_clk);
        arith_word_size_field <= ws;
        e_q <= e;
        optimize <= opt;
        system_clock_divider_select <= dv;
        exp_start <= 1;
        @(posedge sys_clk);
        exp_start <= 0;
        sq = 0;
        mu = 0;
        rf = 0;
        for (k = 0; k < 8000; k++) begin
            @(posedge sys_clk);
            if (exp_refused === 1'b1) rf = 1;
            if (exp_done === 1'b1 || rf) break;
            if (step_ack) step_ack <= 0;
            else if (do_square === 1'b1) begin
                sq++;
                step_ack <= 1;
            end else if (do_multiply === 1'b1) begin
                mu++;
                step_ack <= 1;
            end
        end
        step_ack <= 0;
        if (k == 8000) fails++;
        t1 = k;
    endtask
    // one data-out word write; the model follows only sram words
    task automatic put_word(input logic [1:0] idx, input logic [31:0] d, input logic sram);
        @(posedge sys_clk);
        crc_word_valid <= 1;
        crc_word_idx <= idx;
        crc_word_data <= d;
        crc_src_is_sram <= sram;
        @(posedge sys_clk);
        crc_word_valid <= 0;
        @(posedge sys_clk);
        if (sram) mc = fold(mc, mp, d, bit_swap);
        check("crc value", crc_value, mc);
    endtask
    // seed (sel 0) or polynomial (sel 1) write
    task automatic wr(input logic sel, input logic [31:0] v);
        @(posedge sys_clk);
        if (sel) crc_poly_we <= 1; else crc_val_we <= 1;
        crc_poly_wdata <= v;
        crc_val_wdata <= v;
        @(posedge sys_clk);
        crc_poly_we <= 0;
        crc_val_we <= 0;
        @(posedge sys_clk);
        if (sel) mp = v; else mc = v;
    endtask

    initial begin
        logic [11:0] wl [7] = '{12'h000, 12'h001, 12'h040, 12'h041, 12'h800, 12'h801, 12'hfff};
        logic [63:0] el [6] = '{64'h1, 64'h80, 64'h80, 64'hb5, 64'h1, 64'h0};
        logic [11:0] ew [6] = '{12'h008, 12'h008, 12'h008, 12'h008, 12'h001, 12'h040};
        repeat (8) @(posedge sys_clk);
        srst <= 0;
        @(posedge sys_clk);
        check("poly reset", crc_polynomial_reg, 32'hedb88320);
        check("crc reset", crc_value, 32'hffffffff);
        check("fixed inst", {op_e_instance, op_m_instance}, 6'h25);
        for (int i = 0; i < 16; i++) begin
            rnd = xs(rnd);
            @(posedge sys_clk);
            operand_a_blind_select <= i[1:0];
            operand_b_blind_select <= i[3:2];
            exponent_blind_select <= ~i[1:0];
            modulus_blind_select <= i[2:1];
            op_a_instance <= rnd[2:0];
            op_b_instance <= rnd[5:3];
            repeat (2) @(posedge sys_clk);
            check("a offset", op_a_offset, {rnd[2:0], i[1:0], 6'h00});
            check("b offset", op_b_offset, {rnd[5:3], i[3:2], 6'h00});
            check("e offset", op_e_offset, {3'h4, ~i[1:0], 6'h00});
            check("m offset", op_m_offset, {3'h5, i[2:1], 6'h00});
        end
        $display("test blinding done");
        for (int i = 0; i < 7; i++) begin
            @(posedge sys_clk);
            arith_word_size_field <= wl[i];
            repeat (2) @(posedge sys_clk);
            check("size valid", word_size_valid, (i >= 1 && i <= 4));
            if (i >= 1 && i <= 4) check("blocks", op_block_count, (wl[i] + 63) >> 6);
        end
        $display("test word size done");
        // e kept nonzero where a result is wanted; the last row is the all-zero case
        // optimize mostly cleared
        for (int i = 0; i < 12; i++) begin
            rnd = xs(rnd);
            if (i < 6) exp_model(ew[i], el[i], i == 2 || i == 3);
            else exp_model(64, {rnd, xs(rnd)} | 64'h1, i[0]);
            if (i < 6) run_exp(ew[i], el[i], i == 2 || i == 3, 0);
            else run_exp(12'h040, {rnd, xs(rnd)} | 64'h1, i[0], i[1]);
            check("walk done", rf, 0);
            check("squares", sq, esq);
            check("multiplies", mu, emu);
        end
        run_exp(12'h008, 64'hff, 0, 0);
        t0 = t1;
        run_exp(12'h008, 64'hff, 0, 1);
        check("half rate slower", t1 > t0, 1);
        run_exp(12'h000, 64'h3, 0, 0);
        check("refuse zero size", rf, 1);
        run_exp(12'h801, 64'h3, 1, 0);
        check("refuse big size", rf, 1);
        check("no steps", sq + mu, 0);
        $display("test exponent walk done");
        mc = 32'hffffffff;
        mp = 32'hedb88320;
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            put_word(i[1:0], rnd, 1);
        end
        put_word(2'h0, 32'h12345678, 0);
        wr(1, 32'h04c11db7);
        check("poly write", crc_polynomial_reg, 32'h04c11db7);
        bit_swap <= 1;
        wr(0, 32'hffffffff);
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            put_word(i[1:0], rnd, 1);
        end
        bit_swap <= 0;
        wr(1, 32'h00008408);
        wr(0, 32'h00000000);
        put_word(2'h0, 32'h00000000, 1);
        put_word(2'h1, 32'h00000000, 1);
        check("zero stays zero", crc_value, 32'h00000000);
        $display("test crc done");
        stop_test();
    end
endmodule
